/* hw/lli_pkg.sv */
// Purpose: shared constants for the luminance lookup and interpolation block
// Assumes: 100 MHz clock, AXI4-Lite register access, 12-bit pixels
// Notes: byte offsets are aligned 32-bit words
package lli_pkg;
  localparam int LLI_PIX_W = 12;
  localparam int LLI_OUT8_W = 8;
  localparam int LLI_DROP_BITS = 4;
  localparam int LLI_TABLE_DEPTH = 4096;
  localparam int LLI_ADDR_W = 12;
  localparam int LLI_STEP_SHIFT = 3;
  localparam logic [11:0] LLI_LAST_BREAK = 12'hff8;
  localparam int LLI_FIFO_DEPTH = 32;
  localparam logic [7:0] LLI_OFF_CTRL = 8'h00;
  localparam logic [7:0] LLI_OFF_SELECT = 8'h04;
  localparam logic [7:0] LLI_OFF_INDEX = 8'h08;
  localparam logic [7:0] LLI_OFF_VALUE = 8'h0c;
  localparam logic [7:0] LLI_OFF_STATUS = 8'h10;
  localparam int LLI_CTRL_ENABLE_BIT = 0;
  localparam int LLI_CTRL_FMT8_BIT = 1;
  localparam logic [1:0] LLI_CTRL_RESET = 2'h0;
  localparam logic [0:0] LLI_SEL_LUMINANCE = 1'h0;
  localparam logic [11:0] LLI_INDEX_RESET = 12'h000;
  localparam logic [1:0] LLI_RESP_OKAY = 2'h0;
  localparam logic [1:0] LLI_RESP_SLVERR = 2'h2;
endpackage

/* hw/lli_table_mem.sv */
// Purpose: three-port table memory, one write port and two registered read ports
// Assumes: single clock, reads return one cycle after the address
// Notes: two read ports give both breakpoints of a segment at once
`timescale 1ns/100ps
module lli_table_mem
  import lli_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [LLI_ADDR_W-1:0] wr_addr,
  input wire logic [LLI_PIX_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [LLI_ADDR_W-1:0] rd_addr_a,
  input wire logic [LLI_ADDR_W-1:0] rd_addr_b,
  output logic [LLI_PIX_W-1:0] rd_data_a,
  output logic [LLI_PIX_W-1:0] rd_data_b
);
  logic [LLI_PIX_W-1:0] mem_r [LLI_TABLE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_a <= mem_r[rd_addr_a];
      rd_data_b <= mem_r[rd_addr_b];
    end
  end
endmodule // lli_table_mem

/* hw/lli_fifo.sv */
// Purpose: synchronous valid/ready FIFO
// Assumes: depth is a power of two
// Notes: read data taken straight from the array; no bypass, so empty means out_valid low
`timescale 1ns/100ps
module lli_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wptr_r;
  logic [AW:0] rptr_r;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign count = wptr_r - rptr_r;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem_r[rptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r[AW-1:0]] <= in_data;
    end
  end
endmodule // lli_fifo

/* hw/lli_lookup_interp.sv */
// Purpose: pixel-path luminance lookup with linear interpolation, AXI4-Lite registers
// Assumes: pixels come from same-clock logic with valid/ready; one clock, sync reset
// Notes: three-stage pipeline into a 32-word output FIFO; pipeline stalls on FIFO full
// Operation
// - pixels are 12 bits; table off with 12-bit format passes them unchanged
// - one table memory of 4096 entries, each a 12-bit output code
// - only entries at multiples of eight serve as breakpoints
// - inputs between breakpoints are linearly interpolated from the two neighbours
// - inputs above 4088 output the entry at 4088 without interpolation
// - 8-bit format keeps the upper eight bits of the mapped value
// - a table selector picks the table; only luminance is offered
// - an entry index picks which entry the next value write lands in
// - writing the entry value stores the 12-bit code at the index
// - table enable switches the pixel path onto the loaded table
`timescale 1ns/100ps
module lli_lookup_interp
  import lli_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // pixel input from the converter side
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire logic [LLI_PIX_W-1:0] pix_in_data,
  // formatted pixel output
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output logic [LLI_PIX_W-1:0] pix_out_data,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // registers
  logic [1:0] ctrl_r;
  logic [0:0] table_select_r;
  logic [LLI_ADDR_W-1:0] table_entry_index_r;
  logic [LLI_PIX_W-1:0] last_value_r;
  logic [7:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic table_enable;
  logic fmt8;
  assign table_enable = ctrl_r[LLI_CTRL_ENABLE_BIT];
  assign fmt8 = ctrl_r[LLI_CTRL_FMT8_BIT];

  // write channel: address and data taken in either order
  logic aw_take;
  logic w_take;
  logic do_write;
  logic wr_ctrl;
  logic wr_sel;
  logic wr_idx;
  logic wr_val;
  logic wr_stat;
  logic wr_hit;
  logic strb_lo2;
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign wr_ctrl = (awaddr_r == LLI_OFF_CTRL);
  assign wr_sel = (awaddr_r == LLI_OFF_SELECT);
  assign wr_idx = (awaddr_r == LLI_OFF_INDEX);
  assign wr_val = (awaddr_r == LLI_OFF_VALUE);
  assign wr_stat = (awaddr_r == LLI_OFF_STATUS);
  assign wr_hit = wr_ctrl || wr_sel || wr_idx || wr_val || wr_stat;
  // a code spans the two low byte lanes; a half write would store a torn value
  assign strb_lo2 = wstrb_r[0] && wstrb_r[1];

  // selector check: any non-luminance choice is refused
  logic sel_bad;
  assign sel_bad = wr_sel && (wdata_r != 32'(LLI_SEL_LUMINANCE));

  logic tbl_wr;
  assign tbl_wr = do_write && wr_val && strb_lo2 && (table_select_r == LLI_SEL_LUMINANCE);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= LLI_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        // unmapped offset or refused select answers with an error and changes nothing
        bresp_r <= (wr_hit && !sel_bad) ? LLI_RESP_OKAY : LLI_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= LLI_CTRL_RESET;
      table_select_r <= LLI_SEL_LUMINANCE;
      table_entry_index_r <= LLI_INDEX_RESET;
      last_value_r <= '0;
    end else if (do_write) begin
      if (wr_ctrl && wstrb_r[0]) begin
        ctrl_r <= wdata_r[1:0];
      end
      if (wr_sel && !sel_bad && wstrb_r[0]) begin
        table_select_r <= wdata_r[0:0];
      end
      if (wr_idx && strb_lo2) begin
        table_entry_index_r <= wdata_r[LLI_ADDR_W-1:0];
      end
      if (tbl_wr) begin
        last_value_r <= wdata_r[LLI_PIX_W-1:0];
      end
    end
  end

  // read channel: one-cycle registered answer
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [7:0] ar_word;
  logic ar_take;
  assign ar_word = {s_axi_araddr[7:2], 2'b00};
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // status shows the live handshake levels as they stand when the address is taken
  assign s_axi_arready = !rvalid_r;
  assign rd_hit = (ar_word <= LLI_OFF_STATUS);
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ar_word)
      LLI_OFF_CTRL: rd_mux[1:0] = ctrl_r;
      LLI_OFF_SELECT: rd_mux[0] = table_select_r[0];
      LLI_OFF_INDEX: rd_mux[LLI_ADDR_W-1:0] = table_entry_index_r;
      LLI_OFF_VALUE: rd_mux[LLI_PIX_W-1:0] = last_value_r;
      LLI_OFF_STATUS: rd_mux[2:0] = {pix_out_valid, pix_in_ready, table_enable};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= LLI_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? LLI_RESP_OKAY : LLI_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // pixel pipeline: s1 table read, s2 interpolate, s3 format into fifo
  logic fifo_in_ready;
  logic s1_valid_r;
  logic s2_valid_r;
  logic s3_valid_r;
  logic advance;
  logic [LLI_PIX_W-1:0] s1_pix_r;
  logic [LLI_PIX_W-1:0] s2_pix_r;
  logic [LLI_PIX_W-1:0] s3_data_r;
  logic [LLI_PIX_W-1:0] lo_val;
  logic [LLI_PIX_W-1:0] hi_val;
  // whole pipeline moves together; full fifo stalls the source
  assign advance = !s3_valid_r || fifo_in_ready;
  assign pix_in_ready = advance;

  logic [LLI_ADDR_W-1:0] lo_addr;
  logic [LLI_ADDR_W-1:0] hi_addr;
  logic [LLI_ADDR_W-1:0] next_break;
  logic above_last;
  assign lo_addr = {pix_in_data[LLI_ADDR_W-1:LLI_STEP_SHIFT], 3'h0};
  assign next_break = lo_addr + 12'h008;
  // clamp at last breakpoint
  // top segment has no upper neighbour: both ports read 4088, so the slope is zero
  assign above_last = (lo_addr == LLI_LAST_BREAK);
  assign hi_addr = above_last ? LLI_LAST_BREAK : next_break;

  // table memory
  // entries are not cleared by reset; software loads them before enabling
  lli_table_mem u_mem (
    .clk(clk),
    .wr_en(tbl_wr),
    .wr_addr(table_entry_index_r),
    .wr_data(wdata_r[LLI_PIX_W-1:0]),
    .rd_en(advance),
    .rd_addr_a(lo_addr),
    .rd_addr_b(hi_addr),
    .rd_data_a(lo_val),
    .rd_data_b(hi_val)
  );

  logic signed [13:0] diff;
  logic signed [17:0] prod;
  logic signed [14:0] interp;
  logic [2:0] frac;
  logic [LLI_PIX_W-1:0] mapped;
  logic interp_neg;
  logic interp_over;
  assign frac = s1_pix_r[LLI_STEP_SHIFT-1:0];
  assign diff = $signed({2'b00, hi_val}) - $signed({2'b00, lo_val});
  assign prod = diff * $signed({1'b0, frac});
  assign interp = $signed({3'b000, lo_val}) + 15'(prod >>> LLI_STEP_SHIFT);
  assign interp_neg = (interp < 0);
  assign interp_over = (interp > 15'sd4095);
  assign mapped = interp_neg ? '0 : interp_over ? 12'hfff : interp[LLI_PIX_W-1:0];

  logic [LLI_OUT8_W-1:0] upper8;
  logic [LLI_PIX_W-1:0] fmt_out;
  logic fmt8_s1_r;
  logic fmt8_s2_r;
  assign upper8 = s2_pix_r[LLI_PIX_W-1:LLI_DROP_BITS];
  assign fmt_out = fmt8_s2_r ? {{LLI_DROP_BITS{1'b0}}, upper8} : s2_pix_r;

  // format travels with its pixel, so a mid-stream change never splits one
  logic use_table_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_valid_r <= 1'b0;
      s2_valid_r <= 1'b0;
      s3_valid_r <= 1'b0;
      s1_pix_r <= '0;
      s2_pix_r <= '0;
      s3_data_r <= '0;
      use_table_r <= 1'b0;
      fmt8_s1_r <= 1'b0;
      fmt8_s2_r <= 1'b0;
    end else if (advance) begin
      s1_valid_r <= pix_in_valid;
      s1_pix_r <= pix_in_data;
      use_table_r <= table_enable;
      fmt8_s1_r <= fmt8;
      fmt8_s2_r <= fmt8_s1_r;
      s2_valid_r <= s1_valid_r;
      s2_pix_r <= use_table_r ? mapped : s1_pix_r;
      s3_valid_r <= s2_valid_r;
      s3_data_r <= fmt_out;
    end
  end

  lli_fifo #(
    .WIDTH(LLI_PIX_W),
    .DEPTH(LLI_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(s3_valid_r),
    .in_ready(fifo_in_ready),
    .in_data(s3_data_r),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(pix_out_data)
  );
endmodule // lli_lookup_interp

/* sim/lli_lookup_interp_monitor.sv */
// Purpose: port-level checks for the luminance lookup block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the lookup block
`timescale 1ns/100ps
module lli_lookup_interp_monitor
  import lli_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [LLI_PIX_W-1:0] pix_out_data,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_out_wait;
    pix_out_valid && !pix_out_ready;
  endsequence
  a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_select_refuse: assert property ((s_wr_both ##0 (s_axi_awaddr == LLI_OFF_SELECT
    && s_axi_wdata != 32'h0)) |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == LLI_RESP_SLVERR))
    else $error("bad table select accepted");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_unmapped_read: assert property (s_rd_take ##0 s_axi_araddr[7:2] > LLI_OFF_STATUS[7:2]
    |=> s_axi_rresp == LLI_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // a held head pixel must not slip while the consumer stalls
  a_pix_hold: assert property (s_out_wait |=> pix_out_valid && $stable(pix_out_data))
    else $error("output pixel changed while stalled");
  a_pix_latency: assert property (pix_in_valid && pix_in_ready && !pix_out_valid
    |-> ##[1:4] pix_out_valid)
    else $error("pixel did not reach the output");
  a_reset_idle: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid
    && !pix_out_valid && s_axi_arready)
    else $error("outputs not idle after reset");
endmodule // lli_lookup_interp_monitor

bind lli_lookup_interp lli_lookup_interp_monitor mon_u (.clk(clk), .rst(rst),
  .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .pix_out_valid(pix_out_valid),
  .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* sim/lli_adc_model.sv */
// Purpose: pixel source standing in for the sensor converter
// Assumes: same clock as the lookup block, valid/ready handshake
// Notes: jitter paces the source; sends count pixels upward from first
`timescale 1ns/100ps
module lli_adc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [11:0] first,
  input wire logic [12:0] count,
  input wire logic jitter,
  input wire logic ready,
  output logic valid,
  output logic [11:0] data,
  output logic busy
);
  logic [12:0] left_r = 13'h0;
  logic [11:0] cur_r = 12'h000;
  logic pace_r = 1'b0;
  assign busy = left_r != 13'h0;
  assign valid = busy && pace_r;
  // twelve-bit samples
  // idle lines carry the inverse so a stale sample never looks fresh
  assign data = valid ? cur_r : ~cur_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      left_r <= 13'h0;
      pace_r <= 1'b0;
    end else if (go) begin
      left_r <= count;
      cur_r <= first;
    end else begin
      if (valid && ready) begin
        left_r <= left_r - 13'h1;
        cur_r <= cur_r + 12'h1;
      end
      if (!valid || ready) begin
        pace_r <= jitter;
      end
    end
  end
endmodule // lli_adc_model

/* sim/tb_lli_lookup_interp.sv */
// Purpose: self-checking bench for the luminance lookup block
// Assumes: AXI4-Lite master tasks, pixel source model, random output stalls
// Notes: expected pixels come from a table kept in the bench
`timescale 1ns/100ps
module tb_lli_lookup_interp
  import lli_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pix_out_ready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pix_in_valid, pix_in_ready, pix_out_valid, busy;
  logic go = 1'b0, slow = 1'b0, stall = 1'b0, jitter = 1'b1;
  logic [11:0] pix_in_data, pix_out_data, first = 12'h000;
  logic [12:0] count = 13'h0;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 67070;
  int tbl[4096];
  int expq[$];
  lli_lookup_interp dut_u (.clk(clk), .rst(rst), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
    .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  lli_adc_model adc_u (.clk(clk), .rst(rst), .go(go), .first(first), .count(count),
    .jitter(jitter), .ready(pix_in_ready), .valid(pix_in_valid), .data(pix_in_data),
    .busy(busy));
  initial forever #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_reg(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_pix(input string what, input int e, input logic [11:0] g);
    checks_done++;
    if (g !== 12'(e)) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, 12'(e), g);
    end
  endtask
  function automatic int exp_pix(input int x, input logic en, input logic f8);
    int lo, y;
    lo = x & ~7;
    if (!en) y = x;
    else if (x >= 4088) y = tbl[4088];
    else y = tbl[lo] + (((tbl[lo + 8] - tbl[lo]) * (x & 7)) >>> 3);
    y = (y < 0) ? 0 : (y > 4095) ? 4095 : y;
    return f8 ? y >> 4 : y;
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk_reg("write response", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_reg("read data", ed, s_axi_rdata);
    chk_reg("read response", 32'(er), 32'(s_axi_rresp));
  endtask
  // with stall set the output fifo is filled until the input refuses
  task automatic stream(input int f, input int n, input logic en, input logic f8);
    for (int i = 0; i < n; i++) expq.push_back(exp_pix(f + i, en, f8));
    @(posedge clk);
    first <= 12'(f);
    count <= 13'(n);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (stall && pix_in_ready) @(posedge clk);
    stall <= 1'b0;
    while (busy || expq.size() != 0) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && pix_out_valid && pix_out_ready) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("Error pixel expected none seen %h", pix_out_data);
      end else chk_pix("pixel", expq.pop_front(), pix_out_data);
    end
    pix_out_ready <= !stall && ($random(seed) & 3) != 0;
    jitter <= !slow || ($random(seed) & 1) != 0;
    if (cyc == 80000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axr(LLI_OFF_CTRL, 32'h0, LLI_RESP_OKAY);
    axr(LLI_OFF_INDEX, 32'h0, LLI_RESP_OKAY);
    axr(LLI_OFF_STATUS, 32'h2, LLI_RESP_OKAY);
    axw(LLI_OFF_SELECT, 32'h1, LLI_RESP_SLVERR);
    axw(LLI_OFF_SELECT, 32'h2, LLI_RESP_SLVERR);
    axw(LLI_OFF_SELECT, 32'h0, LLI_RESP_OKAY);
    axr(LLI_OFF_SELECT, 32'h0, LLI_RESP_OKAY);
    axr(8'h20, 32'h0, LLI_RESP_SLVERR);
    axw(8'h24, 32'h5, LLI_RESP_SLVERR);
    stall <= 1'b1;
    stream(0, 4096, 1'b0, 1'b0);
    for (int i = 0; i < 4096; i += 8) begin
      tbl[i] = $random(seed) & 32'hfff;
      axw(LLI_OFF_INDEX, 32'(i), LLI_RESP_OKAY);
      axw(LLI_OFF_VALUE, 32'(tbl[i]), LLI_RESP_OKAY);
    end
    axw(LLI_OFF_INDEX, 32'hfff, LLI_RESP_OKAY);
    axw(LLI_OFF_VALUE, 32'h5a5, LLI_RESP_OKAY);
    axr(LLI_OFF_VALUE, 32'h5a5, LLI_RESP_OKAY);
    axw(LLI_OFF_CTRL, 32'h1, LLI_RESP_OKAY);
    axr(LLI_OFF_STATUS, 32'h3, LLI_RESP_OKAY);
    slow <= 1'b1;
    stream(0, 4096, 1'b1, 1'b0);
    axw(LLI_OFF_CTRL, 32'h3, LLI_RESP_OKAY);
    stream(4000, 96, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule // tb_lli_lookup_interp
